// File: logic/tasc_pkg.sv
// Package of constants and types for the touch converter serial control block
package tasc_pkg;

   // Control word layout, shifted in most significant bit first
   localparam int unsigned CMD_WIDTH        = 8;
   localparam int unsigned CMD_START_POS    = 7;
   localparam int unsigned CMD_CHAN_MSB     = 6;
   localparam int unsigned CMD_CHAN_LSB     = 4;
   localparam int unsigned CMD_MODE_POS     = 3;
   localparam int unsigned CMD_REF_POS      = 2;
   localparam int unsigned CMD_PD_MSB       = 1;
   localparam int unsigned CMD_PD_LSB       = 0;

   // Conversion figures
   localparam int unsigned RESULT_WIDTH     = 12;
   localparam int unsigned RESULT_NARROW    = 8;
   localparam int unsigned FRAME_CLOCKS     = 24;
   localparam int unsigned CNT_WIDTH        = 5;
   localparam logic [CNT_WIDTH-1:0] CNT_CMD_DONE  = 5'h08;
   localparam logic [CNT_WIDTH-1:0] CNT_FRAME_END = 5'h18;

   // Channel address codes and mode encodings
   localparam logic [2:0] CHAN_Y_POS        = 3'h1;
   localparam logic [2:0] CHAN_X_POS        = 3'h5;
   localparam logic       MODE_12BIT        = 1'h0;
   localparam logic       MODE_8BIT         = 1'h1;
   localparam logic [1:0] PD_IRQ_OFF        = 2'h3;

   // Reset value of the control word: low power, touch interrupt on
   localparam logic [7:0] CMD_RESET         = 8'h00;

   typedef struct packed {
      logic       start;
      logic [2:0] channel_address_field;
      logic       mode_bit;
      logic       reference_type_bit;
      logic [1:0] power_down_field;
   } tasc_cmd_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD  = 2'b01,
      ST_CONV = 2'b10
   } tasc_state_type;

   // Converter setting seen by the analog front end
   typedef struct packed {
      logic [2:0] channel;
      logic       single_ended;
      logic [1:0] power_mode;
      logic       narrow;
   } tasc_setting_type;

endpackage

// File: logic/tasc_pin_sync.sv
// Two-stage synchroniser with edge detection for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tasc_pin_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   // Asynchronous pins
   input  wire logic [WIDTH-1:0] pin_i,
   // Synchronised level and edges
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] rise_o,
   output logic      [WIDTH-1:0] fall_o
);
   import tasc_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] last;
   } tasc_sync_type;

   tasc_sync_type sync_reg;
   tasc_sync_type sync_next;

   always_comb begin
      sync_next      = sync_reg;
      sync_next.meta = pin_i;
      sync_next.sync = sync_reg.meta;
      sync_next.last = sync_reg.sync;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   // Edges compare the second and third stages only
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         assign level_o[g] = sync_reg.sync[g];
         assign rise_o[g]  = sync_reg.sync[g] & ~sync_reg.last[g];
         assign fall_o[g]  = ~sync_reg.sync[g] & sync_reg.last[g];
      end
   endgenerate

endmodule
`default_nettype wire

// File: logic/tasc_touch_ctrl.sv
// Touch converter serial control: pen interrupt, command shift-in, result shift-out
`timescale 1ns/1ps
`default_nettype none

// How it works
// - With no touch the interrupt output rests high.
// - A pressed panel drives the interrupt output low toward the host outside frames, unless bits 1 and 0 are both set.
// - The control word is eight bits shifted in msb first, the first high bit being the start.
// - Bits 6 to 4 address the channel and, with the reference bit, set the input mux.
// - Bit 3 picks a 12-bit result when clear and an 8-bit result when set.
// - Bit 2 picks single-ended or differential reference together with the channel bits.
// - Bits 1 and 0 select the power-down behaviour.
// - The host serial clock paces transfers and also drives the conversion itself.
// - One conversion frame lasts 24 serial clocks.
// - Positions are converted to 12-bit X and Y values, or 8-bit ones when bit 3 is set.
module tasc_touch_ctrl #(
   parameter int unsigned DATA_WIDTH = tasc_pkg::RESULT_WIDTH
) (
   // Clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_n_i,
   // Serial link pins from the host
   input  wire logic                      conversion_shift_clock_i,
   input  wire logic                      converter_select_n_i,
   input  wire logic                      command_serial_i,
   // Serial link pins to the host
   output logic                           result_serial_output_o,
   output logic                           touch_interrupt_n_o,
   output logic                           converter_busy_o,
   // Panel front end
   input  wire logic                      panel_touched_i,
   input  wire logic [DATA_WIDTH-1:0]     panel_x_i,
   input  wire logic [DATA_WIDTH-1:0]     panel_y_i,
   input  wire logic [DATA_WIDTH-1:0]     panel_aux_i,
   // Converter setting decoded from the last control word
   output var tasc_pkg::tasc_setting_type setting_o
);
   import tasc_pkg::*;

   localparam int unsigned SYNC_W = 3 + 3 * DATA_WIDTH;

   typedef struct packed {
      tasc_state_type        state;
      logic [CNT_WIDTH-1:0]  clk_cnt;
      logic [CMD_WIDTH-1:0]  cmd_shift;
      tasc_cmd_type          cmd;
      logic [DATA_WIDTH-1:0] result_shift;
      logic                  dout;
      logic                  irq_n;
      logic                  busy;
      tasc_setting_type      setting;
      logic [1:0]            cs_sync;
   } tasc_ctrl_type;

   tasc_ctrl_type ctrl_reg;
   tasc_ctrl_type ctrl_next;

   logic [SYNC_W-1:0] pins_level;
   logic [SYNC_W-1:0] pins_rise;
   logic [SYNC_W-1:0] pins_fall;

   // Panel words are sampled while the panel is steady; bit skew is tolerated
   tasc_pin_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .pin_i      ({panel_aux_i, panel_y_i, panel_x_i, panel_touched_i,
                    command_serial_i, conversion_shift_clock_i}),
      .level_o    (pins_level),
      .rise_o     (pins_rise),
      .fall_o     (pins_fall)
   );

   logic                  dclk_rise;
   logic                  dclk_fall;
   logic                  din;
   logic                  touched;
   logic                  selected;
   logic [DATA_WIDTH-1:0] x_val;
   logic [DATA_WIDTH-1:0] y_val;
   logic [DATA_WIDTH-1:0] aux_val;

   assign dclk_rise = pins_rise[0];
   assign dclk_fall = pins_fall[0];
   assign din       = pins_level[1];
   assign touched   = pins_level[2];
   assign x_val     = pins_level[3 +: DATA_WIDTH];
   assign y_val     = pins_level[3 + DATA_WIDTH +: DATA_WIDTH];
   assign aux_val   = pins_level[3 + 2 * DATA_WIDTH +: DATA_WIDTH];

   // Chip select has its own two stages in the state struct, resting deselected
   assign selected = ~ctrl_reg.cs_sync[1];

   // Picks the converted value for a channel address and reference setting
   function automatic logic [DATA_WIDTH-1:0] pick_sample(
      input tasc_cmd_type          c,
      input logic [DATA_WIDTH-1:0] xv,
      input logic [DATA_WIDTH-1:0] yv,
      input logic [DATA_WIDTH-1:0] av
   );
      logic [DATA_WIDTH-1:0] v;
      v = av;
      if (c.channel_address_field == CHAN_X_POS) begin
         v = xv;
      end else if (c.channel_address_field == CHAN_Y_POS) begin
         v = yv;
      end
      // Auxiliary inputs only measure against a single-ended reference
      if (!c.reference_type_bit && c.channel_address_field != CHAN_X_POS
          && c.channel_address_field != CHAN_Y_POS) begin
         v = '0;
      end
      if (c.mode_bit == MODE_8BIT) begin
         v = {v[DATA_WIDTH-1 -: RESULT_NARROW], {(DATA_WIDTH-RESULT_NARROW){1'b0}}};
      end
      return v;
   endfunction

   tasc_cmd_type cmd_word;

   always_comb begin
      ctrl_next = ctrl_reg;
      cmd_word  = tasc_cmd_type'({ctrl_reg.cmd_shift[CMD_WIDTH-2:0], din});
      ctrl_next.cs_sync = {ctrl_reg.cs_sync[0], converter_select_n_i};

      unique case (ctrl_reg.state)
         ST_IDLE: begin
            ctrl_next.dout    = 1'b0;
            ctrl_next.clk_cnt = '0;
            // Leading low bits are ignored until the first high bit
            if (selected && dclk_rise && din) begin
               ctrl_next.state     = ST_CMD;
               ctrl_next.clk_cnt   = CNT_WIDTH'(1);
               ctrl_next.cmd_shift = CMD_WIDTH'(1);
               ctrl_next.busy      = 1'b1;
            end
         end
         ST_CMD: begin
            if (dclk_rise) begin
               ctrl_next.clk_cnt   = ctrl_reg.clk_cnt + CNT_WIDTH'(1);
               ctrl_next.cmd_shift = cmd_word;
               if (ctrl_reg.clk_cnt + CNT_WIDTH'(1) == CNT_CMD_DONE) begin
                  ctrl_next.state = ST_CONV;
                  ctrl_next.cmd   = cmd_word;
                  ctrl_next.setting.channel      = cmd_word.channel_address_field;
                  ctrl_next.setting.single_ended = cmd_word.reference_type_bit;
                  ctrl_next.setting.power_mode   = cmd_word.power_down_field;
                  ctrl_next.setting.narrow       = cmd_word.mode_bit;
                  // Sample taken at the end of the command, 12-bit wide
                  ctrl_next.result_shift = pick_sample(cmd_word, x_val, y_val, aux_val);
               end
            end
         end
         ST_CONV: begin
            // Result leaves msb first, one bit per falling serial clock edge
            if (dclk_fall) begin
               ctrl_next.dout         = ctrl_reg.result_shift[DATA_WIDTH-1];
               ctrl_next.result_shift = {ctrl_reg.result_shift[DATA_WIDTH-2:0], 1'b0};
            end
            if (dclk_rise) begin
               ctrl_next.clk_cnt = ctrl_reg.clk_cnt + CNT_WIDTH'(1);
               if (ctrl_reg.clk_cnt + CNT_WIDTH'(1) == CNT_FRAME_END) begin
                  ctrl_next.state = ST_IDLE;
                  ctrl_next.busy  = 1'b0;
                  ctrl_next.dout  = 1'b0;
               end
            end
         end
         default: begin
            ctrl_next.state = ST_IDLE;
         end
      endcase

      // Raising chip select abandons any frame in progress
      if (!selected) begin
         ctrl_next.state        = ST_IDLE;
         ctrl_next.busy         = 1'b0;
         ctrl_next.dout         = 1'b0;
         ctrl_next.clk_cnt      = '0;
         ctrl_next.result_shift = '0;
      end

      // Interrupt follows the panel unless powered-on mode disables it or a frame runs
      ctrl_next.irq_n = 1'b1;
      if (touched && ctrl_next.setting.power_mode != PD_IRQ_OFF
          && ctrl_next.state == ST_IDLE) begin
         ctrl_next.irq_n = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg                      <= '0;
         ctrl_reg.state                <= ST_IDLE;
         ctrl_reg.irq_n                <= 1'b1;
         ctrl_reg.cmd                  <= tasc_cmd_type'(CMD_RESET);
         ctrl_reg.cs_sync              <= '1;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   assign result_serial_output_o = ctrl_reg.dout;
   assign touch_interrupt_n_o    = ctrl_reg.irq_n;
   assign converter_busy_o       = ctrl_reg.busy;
   assign setting_o              = ctrl_reg.setting;

endmodule
`default_nettype wire

// File: tb/tasc_touch_ctrl_properties.sv
// Concurrent checks on the touch converter serial control ports
`timescale 1ns/1ps
`default_nettype none
module tasc_touch_ctrl_properties
   import tasc_pkg::*;
(
   // Clock and reset
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_n_i,
   // Watched pins
   input  wire logic                       conversion_shift_clock_i,
   input  wire logic                       converter_select_n_i,
   input  wire logic                       panel_touched_i,
   input  wire logic                       result_serial_output_o,
   input  wire logic                       touch_interrupt_n_o,
   input  wire logic                       converter_busy_o,
   input  wire tasc_pkg::tasc_setting_type setting_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_idle_irq_high: assert property (!panel_touched_i [*8] |-> touch_interrupt_n_o)
      else $error("interrupt low with no touch");
   a_touch_irq_low: assert property ((panel_touched_i && !converter_busy_o
      && setting_o.power_mode != PD_IRQ_OFF) [*8] |-> !touch_interrupt_n_o)
      else $error("touch not flagged");
   a_frame_irq_high: assert property (converter_busy_o [*3] |-> touch_interrupt_n_o)
      else $error("interrupt low during a frame");
   a_pd_mask: assert property ((setting_o.power_mode == PD_IRQ_OFF) [*2]
      |-> touch_interrupt_n_o)
      else $error("interrupt not masked by power field");
   a_abort_quiet: assert property (converter_select_n_i [*5]
      |-> !converter_busy_o && !result_serial_output_o)
      else $error("frame survives deselect");
   a_dout_idle_zero: assert property (!converter_busy_o [*2]
      |-> !result_serial_output_o)
      else $error("result line active while idle");
   a_busy_min_hold: assert property ($rose(converter_busy_o)
      |-> converter_busy_o [*8])
      else $error("frame too short");
   a_setting_in_frame: assert property (!$stable(setting_o)
      |-> converter_busy_o && conversion_shift_clock_i)
      else $error("setting changed outside command completion");
   a_dout_on_fall: assert property (!$stable(result_serial_output_o)
      |-> !conversion_shift_clock_i || converter_select_n_i)
      else $error("result bit changed while serial clock high");

   c_irq_low: cover property ($fell(touch_interrupt_n_o));
   c_frame: cover property ($rose(converter_busy_o));
   c_narrow: cover property (setting_o.narrow && converter_busy_o);
endmodule

bind tasc_touch_ctrl tasc_touch_ctrl_properties u_props (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
   .conversion_shift_clock_i(conversion_shift_clock_i),
   .converter_select_n_i(converter_select_n_i), .panel_touched_i(panel_touched_i),
   .result_serial_output_o(result_serial_output_o),
   .touch_interrupt_n_o(touch_interrupt_n_o), .converter_busy_o(converter_busy_o),
   .setting_o(setting_o)
);
`default_nettype wire

// File: tb/tasc_host_model.sv
// Host-side model that frames conversions on the serial link
`timescale 1ns/1ps
`default_nettype none
module tasc_host_model (
   // Link pins toward the converter
   output logic      sclk_o,
   output logic      sel_n_o,
   output logic      din_o,
   // Pins from the converter
   input  wire logic dout_i,
   input  wire logic busy_i,
   input  wire logic irq_n_i
);
   logic [15:0] rx;
   logic        busy_seen;
   logic        irq_seen;

   initial begin
      sclk_o  = 1'b0;
      sel_n_o = 1'b1;
      din_o   = 1'b0;
   end

   // Serial clock stands low outside frames; len below 24 aborts the frame
   task automatic frame(input logic [7:0] cmd, input int len);
      sel_n_o = 1'b0;
      #80;
      for (int i = 1; i <= len; i++) begin
         din_o = (i <= 8) ? cmd[8 - i] : ~din_o;
         #80 sclk_o = 1'b1;
         if (i > 8) rx = {rx[14:0], dout_i};
         if (i == 12) begin
            busy_seen = busy_i;
            irq_seen  = irq_n_i;
         end
         #80 sclk_o = 1'b0;
      end
      #80 sel_n_o = 1'b1;
      din_o = ~din_o;
   endtask
endmodule
`default_nettype wire

// File: tb/test_tasc_touch_ctrl.sv
// Self-checking bench for the touch converter serial control block
`timescale 1ns/1ps
`default_nettype none
module test_tasc_touch_ctrl;
   import tasc_pkg::*;
   logic             clk, rst_n, touched, sclk, sel_n, din, dout, irq_n, busy;
   logic [11:0]      px, py, pa;
   logic [7:0]       cmd;
   logic [7:0]       cmds[$];
   tasc_setting_type setting;
   int               failures;
   int               compares;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   tasc_touch_ctrl dut (
      .core_clk_i(clk), .rst_n_i(rst_n), .conversion_shift_clock_i(sclk),
      .converter_select_n_i(sel_n), .command_serial_i(din), .result_serial_output_o(dout),
      .touch_interrupt_n_o(irq_n), .converter_busy_o(busy), .panel_touched_i(touched),
      .panel_x_i(px), .panel_y_i(py), .panel_aux_i(pa), .setting_o(setting)
   );

   tasc_host_model u_host (
      .sclk_o(sclk), .sel_n_o(sel_n), .din_o(din), .dout_i(dout), .busy_i(busy),
      .irq_n_i(irq_n)
   );

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Expected result stream: twelve bits msb first, then zeros
   function automatic logic [15:0] model(input logic [7:0] c);
      logic [11:0] v;
      v = (c[6:4] == 3'h5) ? px : (c[6:4] == 3'h1) ? py : (c[2] ? pa : 12'h0);
      if (c[3]) v[3:0] = 4'h0;
      return {v, 4'h0};
   endfunction

   task automatic complete_run;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(32'h2EF65281));
      rst_n   = 1'b0;
      touched = 1'b0;
      px      = 12'($urandom);
      py      = 12'($urandom);
      pa      = 12'($urandom);
      cmds    = '{8'hD4, 8'h9C, 8'hD7, 8'hA0, 8'hA4, 8'h9D, 8'hE6};
      cmds.push_back({1'b1, 7'($urandom)});
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (10) @(negedge clk);
      check("irq_idle", 16'(irq_n), 16'h1);
      check("setting_reset", 16'(setting), 16'h0);
      touched = 1'b1;
      // Host waits for the interrupt before asking for coordinates
      for (int n = 0; n < 40 && irq_n !== 1'b0; n++) begin
         @(negedge clk);
      end
      check("irq_touch", 16'(irq_n), 16'h0);
      if (irq_n !== 1'b0) begin
         complete_run();
      end
      $display("test interrupt done");
      u_host.frame(8'hD4, 10);
      repeat (10) @(negedge clk);
      check("abort_busy", 16'(busy), 16'h0);
      check("abort_dout", 16'(dout), 16'h0);
      $display("test abort done");
      foreach (cmds[k]) begin
         cmd = cmds[k];
         u_host.frame(cmd, 24);
         @(negedge clk);
         check("result", u_host.rx, model(cmd));
         check("setting", 16'(setting), 16'({cmd[6:4], cmd[2], cmd[1:0], cmd[3]}));
         check("busy_mid", 16'(u_host.busy_seen), 16'h1);
         check("irq_mid", 16'(u_host.irq_seen), 16'h1);
         check("busy_end", 16'(busy), 16'h0);
         repeat (10) @(negedge clk);
         check("irq_after", 16'(irq_n), 16'(cmd[1:0] == 2'h3));
         $display("test frame %0d done", k);
      end
      // Reset in mid-run clears the setting and re-arms the interrupt
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      check("reset_setting", 16'(setting), 16'h0);
      check("reset_busy", 16'(busy), 16'h0);
      check("reset_dout", 16'(dout), 16'h0);
      check("reset_irq", 16'(irq_n), 16'h1);
      rst_n = 1'b1;
      repeat (10) @(negedge clk);
      check("irq_rearmed", 16'(irq_n), 16'h0);
      $display("test reset done");
      touched = 1'b0;
      repeat (10) @(negedge clk);
      check("irq_release", 16'(irq_n), 16'h1);
      $display("test release done");
      complete_run();
   end
endmodule
`default_nettype wire
